// ### rtl/ral_pkg.sv
// How it works
// - Minute match: bit 7 disable, resets 1; tens 6..4, units 3..0.
// - Hour match: bit 7 disable, bit 6 unused; 12h: PM bit 5.
// - 24h hour match: tens in bits 5..4, units in bits 3..0.
// - Day match: bit 7 disable, bit 6 unused; tens 5..4, units 3..0.
// - Weekday match: bit 7 disable, bits 6..3 unused, value 2..0.
// - Enabled fields compared; flag set when all first match together.
// - Disabled fields take no part in the comparison at all.
// - Alarm flag holds until cleared; sets again only on new match.
// - With irq enable set, interrupt pin follows the alarm flag.
// - Clearing the flag releases the pin at once; level only.
// - Alarm source has no pulsed interrupt mode.
// - Flag write ANDs: 0 clears a flag, 1 leaves it alone.
// - Flags in bits 7..3: watchdog, count A, count B, second, alarm.
// - Rewriting bits 2..0 repeatedly changes no behaviour.
// - Increments frozen during access; one held, released after access.
package ral_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_MIN_MATCH   = 8'h0A;
    localparam logic [7:0] ADDR_HOUR_MATCH  = 8'h0B;
    localparam logic [7:0] ADDR_DAY_MATCH   = 8'h0C;
    localparam logic [7:0] ADDR_WDAY_MATCH  = 8'h0D;
    // Match register layout
    localparam int         DISABLE_BIT  = 7;
    localparam logic [7:0] MATCH_RESET  = 8'h80;
    localparam int         NUM_FIELDS   = 4;
    localparam int         IDX_MIN      = 0;
    localparam int         IDX_HOUR     = 1;
    localparam int         IDX_DAY      = 2;
    localparam int         IDX_WDAY     = 3;
    localparam logic [7:0] MIN_MASK     = 8'h7F;
    localparam logic [7:0] HOUR_MASK    = 8'h3F;
    localparam logic [7:0] DAY_MASK     = 8'h3F;
    localparam logic [7:0] WDAY_MASK    = 8'h07;
    // Event flag layout
    localparam int         FLAG_WDOG_A  = 7;
    localparam int         FLAG_CNT_A   = 6;
    localparam int         FLAG_CNT_B   = 5;
    localparam int         FLAG_SECOND  = 4;
    localparam int         FLAG_ALARM   = 3;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    localparam logic [7:0] FLAG_PLAIN   = 8'h07;
    // Longest host access
    localparam int         ACCESS_LIMIT_MS = 1000;
    localparam int         CLK_HZ          = 40000000;
    localparam int         ACCESS_LIMIT_CYC =
        (CLK_HZ / 1000) * ACCESS_LIMIT_MS;
    // Increment hold state
    typedef enum logic [1:0] {
        RAL_RUN       = 2'b00,
        RAL_HOLD      = 2'b01,
        RAL_HOLD_PEND = 2'b11
    } ral_hold_st_t;
endpackage

// ### rtl/ral_cmp_if.sv
`timescale 1ns/1ps
// Alarm settings and live time toward the comparator
interface ral_cmp_if;
    logic [7:0] alm [ral_pkg::NUM_FIELDS];
    logic [7:0] now [ral_pkg::NUM_FIELDS];
    logic       match;
    modport cmp (input alm, input now, output match);
    modport ctl (output alm, output now, input match);
endinterface

// ### rtl/ral_cmp.sv
`timescale 1ns/1ps
module ral_cmp (
    // Settings in, match out
    ral_cmp_if.cmp bus
);
    import ral_pkg::*;

    localparam logic [7:0] FIELD_MASK [NUM_FIELDS] =
        '{MIN_MASK, HOUR_MASK, DAY_MASK, WDAY_MASK};

    logic [NUM_FIELDS-1:0] fld_ok;
    logic [NUM_FIELDS-1:0] fld_on;

    // Per-field compare; hour keeps bit 5 so PM or tens both count
    genvar g;
    generate
        for (g = 0; g < NUM_FIELDS; g++) begin : g_fld
            assign fld_on[g] = ~bus.alm[g][DISABLE_BIT];
            assign fld_ok[g] = ~fld_on[g] ||
                ((bus.alm[g] & FIELD_MASK[g]) ==
                 (bus.now[g] & FIELD_MASK[g]));
        end
    endgenerate

    // No enabled field means no alarm, never a constant match
    assign bus.match = (&fld_ok) && (|fld_on);
endmodule

// ### rtl/ral_alarm.sv
`timescale 1ns/1ps
module ral_alarm #(
    parameter int ACCESS_LIMIT = ral_pkg::ACCESS_LIMIT_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // Register access from the serial front end
    input  wire logic       host_busy_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Time counters
    input  wire logic       tick_1hz_i,
    output logic            time_inc_o,
    input  wire logic [7:0] now_minute_i,
    input  wire logic [7:0] now_hour_i,
    input  wire logic [7:0] now_day_i,
    input  wire logic [7:0] now_weekday_i,
    // Other flag sources and control
    input  wire logic [3:0] timer_flag_set_i,
    input  wire logic       alarm_irq_enable_i,
    // Open-drain interrupt pin, active low
    output logic            interrupt_out_one_o,
    output logic            interrupt_out_one_oe_o,
    // Status
    output logic            alarm_flag_o,
    output logic            tick_lost_o,
    output logic            access_long_o
);
    import ral_pkg::*;

    localparam int CW = $clog2(ACCESS_LIMIT + 1);

    ral_cmp_if cmp_bus ();

    logic [7:0]   match_reg [NUM_FIELDS];
    logic [7:0]   event_flags;
    logic [7:0]   next_flags;
    logic [7:0]   flag_set;
    ral_hold_st_t hold_st;
    ral_hold_st_t next_hold_st;
    logic         next_inc;
    logic         next_lost;
    logic         eval_q;
    logic         match_prev;
    logic         alarm_hit;
    logic         flags_wr;
    logic [CW-1:0] busy_cnt;

    // Comparator sees settings and live time
    ral_cmp u_cmp (
        .bus (cmp_bus.cmp)
    );

    assign cmp_bus.now[IDX_MIN]  = now_minute_i;
    assign cmp_bus.now[IDX_HOUR] = now_hour_i;
    assign cmp_bus.now[IDX_DAY]  = now_day_i;
    assign cmp_bus.now[IDX_WDAY] = now_weekday_i;

    genvar g;
    generate
        for (g = 0; g < NUM_FIELDS; g++) begin : g_alm
            assign cmp_bus.alm[g] = match_reg[g];
        end
    endgenerate

    // Match registers; disable bits reset to 1 so nothing fires
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_FIELDS; i++) begin
                match_reg[i] <= MATCH_RESET;
            end
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_MIN_MATCH:  match_reg[IDX_MIN]  <= reg_wdata_i;
                ADDR_HOUR_MATCH: match_reg[IDX_HOUR] <=
                    reg_wdata_i & (HOUR_MASK | 8'h80);
                ADDR_DAY_MATCH:  match_reg[IDX_DAY]  <=
                    reg_wdata_i & (DAY_MASK | 8'h80);
                ADDR_WDAY_MATCH: match_reg[IDX_WDAY] <=
                    reg_wdata_i & (WDAY_MASK | 8'h80);
                default: ;
            endcase
        end
    end

    // Increment hold: counters frozen during access, one kept
    always_comb begin
        next_hold_st = hold_st;
        next_inc     = 1'b0;
        next_lost    = 1'b0;
        case (hold_st)
            RAL_RUN: begin
                if (host_busy_i) begin
                    next_hold_st = tick_1hz_i ? RAL_HOLD_PEND : RAL_HOLD;
                end else begin
                    next_inc = tick_1hz_i;
                end
            end
            RAL_HOLD: begin
                if (!host_busy_i) begin
                    next_hold_st = RAL_RUN;
                    next_inc     = tick_1hz_i;
                end else if (tick_1hz_i) begin
                    next_hold_st = RAL_HOLD_PEND;
                end
            end
            RAL_HOLD_PEND: begin
                // Only one request is stored; a second is lost
                next_lost = tick_1hz_i;
                if (!host_busy_i) begin
                    next_hold_st = RAL_RUN;
                    next_inc     = 1'b1;
                end
            end
            default: begin
                next_hold_st = RAL_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_st     <= RAL_RUN;
            time_inc_o  <= 1'b0;
            tick_lost_o <= 1'b0;
        end else begin
            hold_st     <= next_hold_st;
            time_inc_o  <= next_inc;
            tick_lost_o <= next_lost;
        end
    end

    // Long access watch; beyond one second ticks may be lost
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt      <= '0;
            access_long_o <= 1'b0;
        end else if (!host_busy_i) begin
            busy_cnt      <= '0;
            access_long_o <= 1'b0;
        end else begin
            if (busy_cnt != CW'(ACCESS_LIMIT)) begin
                busy_cnt <= busy_cnt + 1'b1;
            end
            access_long_o <= (busy_cnt == CW'(ACCESS_LIMIT));
        end
    end

    // Compare one cycle after the counters took the increment
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            eval_q     <= 1'b0;
            match_prev <= 1'b0;
        end else begin
            eval_q <= time_inc_o;
            if (eval_q) begin
                match_prev <= cmp_bus.match;
            end
        end
    end

    // A hit needs a fresh match, not one that merely holds
    assign alarm_hit = eval_q && cmp_bus.match && !match_prev;

    assign flags_wr = reg_wr_i && (reg_addr_i == ADDR_EVENT_FLAGS);

    // Set sources, bits 7..3
    always_comb begin
        flag_set              = '0;
        flag_set[FLAG_WDOG_A] = timer_flag_set_i[3];
        flag_set[FLAG_CNT_A]  = timer_flag_set_i[2];
        flag_set[FLAG_CNT_B]  = timer_flag_set_i[1];
        flag_set[FLAG_SECOND] = timer_flag_set_i[0];
        flag_set[FLAG_ALARM]  = alarm_hit;
    end

    // Write ANDs the flags; a set in the same cycle wins
    always_comb begin
        next_flags = event_flags;
        if (flags_wr) begin
            next_flags = (event_flags & reg_wdata_i & ~FLAG_PLAIN)
                       | (reg_wdata_i & FLAG_PLAIN);
        end
        next_flags = next_flags | flag_set;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            event_flags <= FLAGS_RESET;
        end else begin
            event_flags <= next_flags;
        end
    end

    // Pin level tracks the next flag so a clear releases it at once
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interrupt_out_one_oe_o <= 1'b0;
            interrupt_out_one_o    <= 1'b0;
            alarm_flag_o           <= 1'b0;
        end else begin
            interrupt_out_one_oe_o <= alarm_irq_enable_i &&
                                      next_flags[FLAG_ALARM];
            interrupt_out_one_o    <= 1'b0;
            alarm_flag_o           <= next_flags[FLAG_ALARM];
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                ADDR_EVENT_FLAGS: reg_rdata_o <= event_flags;
                ADDR_MIN_MATCH:   reg_rdata_o <= match_reg[IDX_MIN];
                ADDR_HOUR_MATCH:  reg_rdata_o <= match_reg[IDX_HOUR];
                ADDR_DAY_MATCH:   reg_rdata_o <= match_reg[IDX_DAY];
                ADDR_WDAY_MATCH:  reg_rdata_o <= match_reg[IDX_WDAY];
                default:          reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_FLAG_NEEDS_MATCH: assert property (
        $rose(event_flags[FLAG_ALARM]) |->
            $past(eval_q) && $past(cmp_bus.match) && !$past(match_prev))
        else $error("alarm flag rose without fresh match");

    AST_FLAG_HOLDS: assert property (
        event_flags[FLAG_ALARM] &&
        !(flags_wr && !reg_wdata_i[FLAG_ALARM]) |=>
            event_flags[FLAG_ALARM])
        else $error("alarm flag dropped without a clear");

    AST_PIN_FOLLOWS: assert property (
        interrupt_out_one_oe_o ==
            ($past(alarm_irq_enable_i) && event_flags[FLAG_ALARM]))
        else $error("interrupt pin does not follow alarm flag");

    AST_CLEAR_RELEASES: assert property (
        flags_wr && !reg_wdata_i[FLAG_ALARM] && !alarm_hit |=>
            !interrupt_out_one_oe_o && !event_flags[FLAG_ALARM])
        else $error("clear did not release interrupt pin");

    AST_WRITE_ONE_KEEPS: assert property (
        flags_wr && reg_wdata_i[FLAG_CNT_A] |=>
            event_flags[FLAG_CNT_A] == $past(event_flags[FLAG_CNT_A]) ||
            $past(timer_flag_set_i[2]))
        else $error("writing one changed a flag");

    AST_SOURCE_SETS: assert property (
        timer_flag_set_i[3] |=> event_flags[FLAG_WDOG_A])
        else $error("watchdog flag not set by its source");

    AST_LOW_BITS_ONLY: assert property (
        flags_wr && reg_wdata_i[FLAG_ALARM] && !alarm_hit |=>
            event_flags[FLAG_ALARM] == $past(event_flags[FLAG_ALARM]) &&
            (event_flags & FLAG_PLAIN) == ($past(reg_wdata_i) & FLAG_PLAIN))
        else $error("low bit rewrite disturbed alarm flag");

    AST_FROZEN_ACCESS: assert property (
        host_busy_i && tick_1hz_i ##1 host_busy_i [*2] ##1 !host_busy_i
            |-> !time_inc_o ##1 time_inc_o)
        else $error("held increment not released after access");

    AST_NO_RETRIGGER: assert property (
        eval_q && match_prev && cmp_bus.match && flags_wr &&
        !reg_wdata_i[FLAG_ALARM] |=> !event_flags[FLAG_ALARM])
        else $error("holding match set the flag again");

    // Minute alone enabled: match must depend on minutes only
    AST_DISABLED_IGNORED: assert property (
        !match_reg[IDX_MIN][DISABLE_BIT] &&
        match_reg[IDX_HOUR][DISABLE_BIT] &&
        match_reg[IDX_DAY][DISABLE_BIT] &&
        match_reg[IDX_WDAY][DISABLE_BIT] |->
            cmp_bus.match == ((match_reg[IDX_MIN] & MIN_MASK) ==
                              (now_minute_i & MIN_MASK)))
        else $error("disabled field affected match");

    // Level interrupt: no release while the flag is left alone
    AST_NO_PULSE: assert property (
        interrupt_out_one_oe_o && alarm_irq_enable_i && !flags_wr |=>
            interrupt_out_one_oe_o)
        else $error("alarm interrupt released without a clear");

    // Stored match fields keep their digits and disable bit
    AST_MIN_STORED: assert property (
        reg_wr_i && reg_addr_i == ADDR_MIN_MATCH |=>
            match_reg[IDX_MIN] == $past(reg_wdata_i))
        else $error("minute match register not stored");

    AST_HOUR_STORED: assert property (
        reg_wr_i && reg_addr_i == ADDR_HOUR_MATCH |=>
            (match_reg[IDX_HOUR] & HOUR_MASK) ==
            ($past(reg_wdata_i) & HOUR_MASK) &&
            match_reg[IDX_HOUR][DISABLE_BIT] ==
            $past(reg_wdata_i[DISABLE_BIT]))
        else $error("hour match field not stored");

    AST_WDAY_STORED: assert property (
        reg_wr_i && reg_addr_i == ADDR_WDAY_MATCH |=>
            (match_reg[IDX_WDAY] & WDAY_MASK) ==
            ($past(reg_wdata_i) & WDAY_MASK) &&
            match_reg[IDX_WDAY][DISABLE_BIT] ==
            $past(reg_wdata_i[DISABLE_BIT]))
        else $error("weekday match field not stored");

    // A second held tick is reported, never silently dropped
    AST_LOST_REPORTED: assert property (
        hold_st == RAL_HOLD_PEND && tick_1hz_i |=> tick_lost_o)
        else $error("second tick during access not reported");

    AST_NO_INC_BUSY: assert property (
        host_busy_i |=> !time_inc_o)
        else $error("counters incremented during access");

    AST_INC_WHEN_FREE: assert property (
        hold_st == RAL_RUN && !host_busy_i && tick_1hz_i |=>
            time_inc_o)
        else $error("tick outside access not passed on");

    AST_LONG_CLEARS: assert property (
        !host_busy_i |=> !access_long_o)
        else $error("long access flag outside an access");

    // Set beats a clear landing in the same cycle
    AST_HIT_SETS: assert property (
        alarm_hit |=> event_flags[FLAG_ALARM] && alarm_flag_o)
        else $error("fresh match did not set the alarm flag");

    COV_ALARM_SET: cover property ($rose(event_flags[FLAG_ALARM]));
    COV_HELD_TICK: cover property (hold_st == RAL_HOLD_PEND ##1
                                   hold_st == RAL_RUN);
    COV_IRQ_CLEAR: cover property (interrupt_out_one_oe_o ##1
                                   !interrupt_out_one_oe_o);
    COV_TICK_LOST: cover property (tick_lost_o);
    COV_LONG_ACC:  cover property ($rose(access_long_o));
endmodule

// ### bench/ral_time_model.sv
`timescale 1ns/1ps
// Time counters that sit behind the alarm block
module ral_time_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Preset and released increment
    input  wire logic        load_i,
    input  wire logic [31:0] load_val_i,
    input  wire logic        time_inc_i,
    // Live counters {weekday, day, hour, minute}
    output logic      [31:0] now_o
);
    logic [7:0] next_min;
    // Minute only; no carry into hours, the tests never need it
    always_comb begin
        next_min = now_o[7:0] + 8'h01;
        if (now_o[3:0] == 4'h9) begin
            next_min = {now_o[7:4] + 4'h1, 4'h0};
        end
        if (now_o[7:0] == 8'h59) begin
            next_min = 8'h00;
        end
    end
    // Moves only on released increments, so held ticks stay held
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            now_o <= 32'h0;
        end else if (load_i) begin
            now_o <= load_val_i;
        end else if (time_inc_i) begin
            now_o[7:0] <= next_min;
        end
    end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import ral_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        busy      = 1'b0;
    logic        wr        = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [7:0]  wdata     = 8'h00;
    logic        tick      = 1'b0;
    logic [3:0]  tset      = 4'h0;
    logic        irq_en    = 1'b1;
    logic        load      = 1'b0;
    logic [31:0] load_val  = 32'h0;
    logic [31:0] now;
    logic [7:0]  rdata;
    logic        inc, pin_q, pin_oe, flag, lost, long_acc;
    // Open-drain pin with pull-up
    wire         pin_n = pin_oe ? pin_q : 1'b1;
    int          fails = 0;
    int          n_checks = 0;
    int          n_inc = 0;
    int          n_lost = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    ral_alarm #(.ACCESS_LIMIT(20)) i_dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .host_busy_i(busy), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .tick_1hz_i(tick), .time_inc_o(inc),
        .now_minute_i(now[7:0]), .now_hour_i(now[15:8]),
        .now_day_i(now[23:16]), .now_weekday_i(now[31:24]),
        .timer_flag_set_i(tset), .alarm_irq_enable_i(irq_en),
        .interrupt_out_one_o(pin_q), .interrupt_out_one_oe_o(pin_oe),
        .alarm_flag_o(flag), .tick_lost_o(lost), .access_long_o(long_acc)
    );
    ral_time_model i_time (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .load_i(load),
        .load_val_i(load_val), .time_inc_i(inc), .now_o(now)
    );

    // Pulse counters for increments and lost ticks
    always @(posedge sys_clk_i) begin
        if (inc === 1'b1) n_inc++;
        if (lost === 1'b1) n_lost++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // One write strobe, then a quiet cycle before the next request
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        cyc(1);
        chk(rdata, exp);
    endtask
    // Preset the counters, then one second tick; flag lands by cycle 3
    task automatic step(input logic [31:0] v);
        load_val = v;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(4);
    endtask

    task automatic t_reset;
        rd_chk(ADDR_MIN_MATCH, MATCH_RESET);
        rd_chk(ADDR_HOUR_MATCH, MATCH_RESET);
        rd_chk(ADDR_DAY_MATCH, MATCH_RESET);
        rd_chk(ADDR_WDAY_MATCH, MATCH_RESET);
        rd_chk(ADDR_EVENT_FLAGS, FLAGS_RESET);
        wr_reg(8'h0E, 8'h55);
        rd_chk(8'h0E, 8'h00);
        wr_reg(ADDR_HOUR_MATCH, 8'hFF);
        rd_chk(ADDR_HOUR_MATCH, 8'hBF);
        wr_reg(ADDR_DAY_MATCH, 8'hFF);
        rd_chk(ADDR_DAY_MATCH, 8'hBF);
        wr_reg(ADDR_WDAY_MATCH, 8'hFE);
        rd_chk(ADDR_WDAY_MATCH, 8'h86);
        $display("test reset done");
    endtask

    // Minute only; disabled hour and day hold values that never match
    task automatic t_alarm;
        wr_reg(ADDR_MIN_MATCH, 8'h05);
        step(32'h04150304);
        chk(flag, 1'b1);
        chk(pin_n, 1'b0);
        step(32'h04150305);
        chk(flag, 1'b1);
        // Clear alarm only; low bits go back as they were, zero
        wr_reg(ADDR_EVENT_FLAGS, 8'hF0);
        chk(flag, 1'b0);
        chk(pin_n, 1'b1);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        irq_en = 1'b0;
        step(32'h04150304);
        chk(flag, 1'b1);
        chk(pin_n, 1'b1);
        irq_en = 1'b1;
        wr_reg(ADDR_EVENT_FLAGS, 8'hF0);
        $display("test alarm done");
    endtask

    // All four fields; weekday off by one first
    task automatic t_multi;
        wr_reg(ADDR_MIN_MATCH, 8'h10);
        wr_reg(ADDR_HOUR_MATCH, 8'h08);
        wr_reg(ADDR_DAY_MATCH, 8'h15);
        wr_reg(ADDR_WDAY_MATCH, 8'h03);
        step(32'h02150809);
        chk(flag, 1'b0);
        step(32'h03150809);
        chk(flag, 1'b1);
        wr_reg(ADDR_EVENT_FLAGS, 8'hF0);
        $display("test multi done");
    endtask

    task automatic t_flags;
        tset = 4'h4;
        cyc(1);
        tset = 4'h0;
        rd_chk(ADDR_EVENT_FLAGS, 8'h40);
        tset = 4'hB;
        cyc(1);
        tset = 4'h0;
        rd_chk(ADDR_EVENT_FLAGS, 8'hF0);
        wr_reg(ADDR_EVENT_FLAGS, 8'h78);
        rd_chk(ADDR_EVENT_FLAGS, 8'h70);
        repeat (2) wr_reg(ADDR_EVENT_FLAGS, 8'hF8);
        rd_chk(ADDR_EVENT_FLAGS, 8'h70);
        wr_reg(ADDR_EVENT_FLAGS, 8'h00);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        $display("test flags done");
    endtask

    // Two ticks during a long access: one held, one lost
    task automatic t_busy;
        int n;
        busy = 1'b1;
        cyc(1);
        n = n_inc;
        repeat (2) begin
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            cyc(2);
        end
        cyc(20);
        chk(8'(n_inc - n), 8'h00);
        chk(8'(n_lost), 8'h01);
        chk(long_acc, 1'b1);
        busy = 1'b0;
        cyc(3);
        chk(8'(n_inc - n), 8'h01);
        // Short access: tick at its start, released right after
        n = n_inc;
        busy = 1'b1;
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(2);
        busy = 1'b0;
        cyc(3);
        chk(8'(n_inc - n), 8'h01);
        chk(long_acc, 1'b0);
        $display("test busy done");
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        cyc(2);
        resetn_i = 1'b1;
        cyc(1);
        t_reset();
        t_alarm();
        t_multi();
        t_flags();
        t_busy();
        final_report();
    end

    // Whole run is about 120 cycles
    initial begin
        #(25 * 5000);
        fails++;
        final_report();
    end
endmodule
